// [design/timer_consts.vh]
// Purpose: Constants for the five-channel timer control block
// Assumes: Included by the timer design files only
// Notes: Offsets are word indices on an AXI4-Lite slave, one 32-bit word each
`ifndef TIMER_CONSTS_VH
`define TIMER_CONSTS_VH
// Per-channel window: channel n sits at n * stride
`define CH_STRIDE_SHIFT 5
`define OFS_COUNTER_CONTROL 3'h0
`define OFS_PIN_FUNCTION 3'h1
`define OFS_CHANNEL_COUNTER 3'h2
`define OFS_GENERAL_REG_A 3'h3
`define OFS_GENERAL_REG_B 3'h4
`define OFS_STATUS_FLAGS 3'h5
// Global window at channel slot 5
`define GLOBAL_SLOT 3'h5
`define OFS_SYNC_GROUP 3'h0
`define OFS_PHASE_COUNT 3'h1
// Field positions
`define CLR_SRC_HI 6
`define CLR_SRC_LO 5
`define EXT_EDGE_HI 4
`define EXT_EDGE_LO 3
`define PSC_HI 2
`define FN_B_HI 6
`define FN_B_LO 4
`define FN_A_HI 2
`define FIXED_ONE_BIT 3
// Reset values
`define COUNTER_CONTROL_RST 8'h00
`define PIN_FUNCTION_RST 8'h08
`define CHANNEL_COUNTER_RST 16'h0000
`define GENERAL_REG_RST 16'hffff
// Clear source codes
`define CLR_NONE 2'h0
`define CLR_BY_A 2'h1
`define CLR_BY_B 2'h2
`define CLR_SYNC 2'h3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// [design/timer_channel.v]
// Purpose: One timer channel: counter, general registers, flags, pins
// Assumes: Count ticks and pin edges arrive already synchronised
// Notes: Writes from the bus win over counting in the same cycle
`timescale 1ns/100ps
`default_nettype none
`include "timer_consts.vh"
module timer_channel #(
  parameter TOGGLE_OK = 1
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  input wire init,
  // Count control
  input wire tick,
  input wire down,
  input wire [1:0] clr_sel,
  input wire sync_clr,
  input wire [2:0] fn_a,
  input wire [2:0] fn_b,
  // Capture pin edges
  input wire rise_a,
  input wire fall_a,
  input wire rise_b,
  input wire fall_b,
  // Register writes
  input wire wr_cnt,
  input wire wr_gra,
  input wire wr_grb,
  input wire wr_flags,
  input wire [1:0] be,
  input wire [15:0] wdata,
  // State
  output reg [15:0] channel_counter,
  output reg [15:0] general_reg_a,
  output reg [15:0] general_reg_b,
  output reg match_capture_flag_a,
  output reg match_capture_flag_b,
  output reg ovf_flag,
  output reg clear_evt,
  // Pins
  output reg pin_a_out,
  output reg pin_a_oe,
  output reg pin_b_out,
  output reg pin_b_oe
);
  function cap_hit;
    input [2:0] fn;
    input r;
    input f;
    begin
      cap_hit = fn[2] & (fn[1] ? (r | f) : (fn[0] ? f : r));
    end
  endfunction

  function [15:0] merge;
    input [15:0] old;
    begin
      merge = {be[1] ? wdata[15:8] : old[15:8],
               be[0] ? wdata[7:0] : old[7:0]};
    end
  endfunction

  reg clr_pend;
  wire [15:0] step = down ? channel_counter - 16'h0001 :
                            channel_counter + 16'h0001;
  wire [15:0] new_cnt = clr_pend ? 16'h0000 : step;
  wire cap_a = cap_hit(fn_a, rise_a, fall_a);
  wire cap_b = cap_hit(fn_b, rise_b, fall_b);
  wire cmp_a = tick & ~fn_a[2] & (new_cnt == general_reg_a);
  wire cmp_b = tick & ~fn_b[2] & (new_cnt == general_reg_b);
  wire ev_a = cap_a | cmp_a;
  wire ev_b = cap_b | cmp_b;
  wire trig = (clr_sel == `CLR_BY_A & ev_a) |
              (clr_sel == `CLR_BY_B & ev_b);
  wire wrap = tick & ~clr_pend &
              (down ? channel_counter == 16'h0000 :
                      channel_counter == 16'hffff);

  // Output level chosen by the compare setting; no toggle where absent
  function drive;
    input [2:0] fn;
    input cur;
    begin
      case (fn[1:0])
        2'h1: drive = 1'b0;
        2'h2: drive = 1'b1;
        2'h3: drive = TOGGLE_OK ? ~cur : 1'b1;
        default: drive = cur;
      endcase
    end
  endfunction

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      channel_counter <= `CHANNEL_COUNTER_RST;
      general_reg_a <= `GENERAL_REG_RST;
      general_reg_b <= `GENERAL_REG_RST;
      match_capture_flag_a <= 1'b0;
      match_capture_flag_b <= 1'b0;
      ovf_flag <= 1'b0;
      clr_pend <= 1'b0;
      clear_evt <= 1'b0;
      pin_a_out <= 1'b0;
      pin_b_out <= 1'b0;
      pin_a_oe <= 1'b0;
      pin_b_oe <= 1'b0;
    end else if (init) begin
      channel_counter <= `CHANNEL_COUNTER_RST;
      general_reg_a <= `GENERAL_REG_RST;
      general_reg_b <= `GENERAL_REG_RST;
      match_capture_flag_a <= 1'b0;
      match_capture_flag_b <= 1'b0;
      ovf_flag <= 1'b0;
      clr_pend <= 1'b0;
      clear_evt <= 1'b0;
      pin_a_out <= 1'b0;
      pin_b_out <= 1'b0;
      pin_a_oe <= 1'b0;
      pin_b_oe <= 1'b0;
    end else begin
      if (wr_cnt)
        channel_counter <= merge(channel_counter);
      else if (tick)
        channel_counter <= new_cnt;
      // Clear waits for the next count tick; a new trigger re-arms it
      clr_pend <= trig | (clr_sel == `CLR_SYNC & sync_clr) |
                  (clr_pend & ~tick);
      clear_evt <= trig;
      if (wr_gra)
        general_reg_a <= merge(general_reg_a);
      else if (cap_a)
        general_reg_a <= channel_counter;
      if (wr_grb)
        general_reg_b <= merge(general_reg_b);
      else if (cap_b)
        general_reg_b <= channel_counter;
      // Set wins over a clear written in the same cycle
      match_capture_flag_a <= ev_a | (match_capture_flag_a &
                              ~(wr_flags & be[0] & ~wdata[0]));
      match_capture_flag_b <= ev_b | (match_capture_flag_b &
                              ~(wr_flags & be[0] & ~wdata[1]));
      ovf_flag <= wrap | (ovf_flag & ~(wr_flags & be[0] & ~wdata[2]));
      if (cmp_a)
        pin_a_out <= drive(fn_a, pin_a_out);
      if (cmp_b)
        pin_b_out <= drive(fn_b, pin_b_out);
      pin_a_oe <= ~fn_a[2] & (fn_a[1:0] != 2'h0);
      pin_b_oe <= ~fn_b[2] & (fn_b[1:0] != 2'h0);
    end
  end
endmodule
`default_nettype wire

// [design/timer_unit.v]
// Purpose: Five-channel 16-bit timer with clock, clear and pin control
// Assumes: AXI4-Lite master keeps one write and one read in flight
// Notes: standby is a level from logic on clk_sys and reinitialises
//
// Operation
// - Every channel has a counter control and a pin function register.
// - Reset or standby loads counter control bits 6 to 0 with zero.
// - Clear field 00 none, 01 on A event, 10 on B event, 11 sync.
// - Clear comes from compare match or capture, per register function.
// - Sync setting clears with the other synchronised counters.
// - Edge field: 00 rising, 01 falling, 1x both edges.
// - Prescaler: clock, /2, /4, /8, then external pins A to D.
// - Internal divided clocks count on falling edges only.
// - External pins count the edges chosen by the edge field.
// - Channel 2 phase mode ignores edge and prescaler fields.
// - Reset or standby loads pin function with bit 3 set, rest zero.
// - B field 000 to 011: compare with no drive, 0, 1, toggle.
// - B field 100, 101, 110 capture on rising, falling, both.
// - A field uses the same encoding for register A.
// - Compare pins drive 0 after reset until the first match.
// - Channel 2 drives 1 where toggle is selected.
// - Pin function bit 3 always reads 1; software writes 1.
// - Bit 7 of both registers has no effect; its read is undefined.
// - Each counter increments on every tick of its source; channel 2 phase mode also decrements.
// - Capture copies counter to the register and sets its flag.
`timescale 1ns/100ps
`default_nettype none
`include "timer_consts.vh"
module timer_unit (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  input wire standby,
  // AXI4-Lite write
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // External clock pins A to D
  input wire [3:0] ext_clock_pin,
  // Compare and capture pins, one bit per channel
  input wire [4:0] compare_capture_pin_a_in,
  output wire [4:0] compare_capture_pin_a_out,
  output wire [4:0] compare_capture_pin_a_oe,
  input wire [4:0] compare_capture_pin_b_in,
  output wire [4:0] compare_capture_pin_b_out,
  output wire [4:0] compare_capture_pin_b_oe
);
  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  reg [39:0] counter_control;
  reg [39:0] pin_function_control;
  reg [4:0] sync_group_control;
  reg phase_count_enable;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Three stages; a change is accepted once stages two and three agree
  wire [13:0] raw = {compare_capture_pin_b_in, compare_capture_pin_a_in,
                     ext_clock_pin};
  reg [13:0] sync1;
  reg [13:0] sync2;
  reg [13:0] sync3;
  reg [13:0] level;
  wire [13:0] agree = ~(sync2 ^ sync3);
  wire [13:0] rise = agree & sync3 & ~level;
  wire [13:0] fall = agree & ~sync3 & level;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1 <= 14'h0000;
      sync2 <= 14'h0000;
      sync3 <= 14'h0000;
      level <= 14'h0000;
    end else begin
      sync1 <= raw;
      sync2 <= sync1;
      sync3 <= sync2;
      level <= (level & ~agree) | (sync3 & agree);
    end
  end

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  // Each divided rate ticks once per period, at its falling edge
  reg [2:0] div;
  wire [3:0] int_tick = {div == 3'h7, div[1:0] == 2'h3, div[0],
                         1'b1};

  always @(posedge clk_sys or posedge rst) begin
    if (rst)
      div <= 3'h0;
    else
      div <= div + 3'h1;
  end

  // ----------------------------------------------------------------
  // Phase counting on channel 2, from pins A and B
  // ----------------------------------------------------------------
  wire ph_tick = rise[0] | fall[0] | rise[1] | fall[1];
  wire ph_up = (rise[0] & ~level[1]) | (fall[0] & level[1]) |
               (rise[1] & level[0]) | (fall[1] & ~level[0]);

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  wire [79:0] cnt_bus;
  wire [79:0] gra_bus;
  wire [79:0] grb_bus;
  wire [14:0] flag_bus;
  wire [4:0] clear_evt;
  wire [4:0] chan_tick;
  wire [4:0] chan_down;

  // Bus write decode
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg aw_full;
  reg w_full;
  wire wr_go = aw_full & w_full & ~s_axi_bvalid;
  wire [2:0] wr_slot = aw_addr[7:5];
  wire [2:0] wr_sub = aw_addr[4:2];
  wire init = standby;
  // Any sync-group channel that clears itself clears each group channel whose clear field is 11 sync
  wire grp_clr = |(clear_evt & sync_group_control);

  genvar i;
  generate
    for (i = 0; i < 5; i = i + 1) begin : g_ch
      wire [7:0] cc = counter_control[8*i+7:8*i];
      wire [7:0] pf = pin_function_control[8*i+7:8*i];
      wire [1:0] pin_sel = cc[1:0];
      wire er = rise[pin_sel];
      wire ef = fall[pin_sel];
      wire ext = cc[`EXT_EDGE_HI] ? (er | ef) :
                 (cc[`EXT_EDGE_LO] ? ef : er);
      wire src = cc[`PSC_HI] ? ext : int_tick[cc[1:0]];
      wire ph = (i == 2) & phase_count_enable;
      wire hit = wr_go & (wr_slot == i);
      assign chan_tick[i] = ph ? ph_tick : src;
      assign chan_down[i] = ph & ~ph_up;
      timer_channel #(
        .TOGGLE_OK(i != 2)
      ) u_ch (
        .clk_sys(clk_sys),
        .rst(rst),
        .init(init),
        .tick(chan_tick[i]),
        .down(chan_down[i]),
        .clr_sel(cc[`CLR_SRC_HI:`CLR_SRC_LO]),
        .sync_clr(grp_clr & sync_group_control[i]),
        .fn_a(pf[`FN_A_HI:0]),
        .fn_b(pf[`FN_B_HI:`FN_B_LO]),
        .rise_a(rise[4+i]),
        .fall_a(fall[4+i]),
        .rise_b(rise[9+i]),
        .fall_b(fall[9+i]),
        .wr_cnt(hit & wr_sub == `OFS_CHANNEL_COUNTER),
        .wr_gra(hit & wr_sub == `OFS_GENERAL_REG_A),
        .wr_grb(hit & wr_sub == `OFS_GENERAL_REG_B),
        .wr_flags(hit & wr_sub == `OFS_STATUS_FLAGS),
        .be(w_strb[1:0]),
        .wdata(w_data[15:0]),
        .channel_counter(cnt_bus[16*i+15:16*i]),
        .general_reg_a(gra_bus[16*i+15:16*i]),
        .general_reg_b(grb_bus[16*i+15:16*i]),
        .match_capture_flag_a(flag_bus[3*i]),
        .match_capture_flag_b(flag_bus[3*i+1]),
        .ovf_flag(flag_bus[3*i+2]),
        .clear_evt(clear_evt[i]),
        .pin_a_out(compare_capture_pin_a_out[i]),
        .pin_a_oe(compare_capture_pin_a_oe[i]),
        .pin_b_out(compare_capture_pin_b_out[i]),
        .pin_b_oe(compare_capture_pin_b_oe[i])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  wire wr_hit_ch = wr_slot < `GLOBAL_SLOT & wr_sub <= `OFS_STATUS_FLAGS;
  wire wr_hit_gl = wr_slot == `GLOBAL_SLOT & wr_sub <= `OFS_PHASE_COUNT;
  wire [5:0] sel_bit = {3'h0, wr_slot} << 3;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else begin
      // Address and data are taken independently, in either order
      s_axi_awready <= s_axi_awvalid & ~aw_full & ~s_axi_awready;
      s_axi_wready <= s_axi_wvalid & ~w_full & ~s_axi_wready;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_hit_ch | wr_hit_gl) ? `RESP_OKAY :
                                                 `RESP_SLVERR;
      end else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control register writes
  // ----------------------------------------------------------------
  // Bit 7 is not stored, so any value written there has no effect
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      counter_control <= {5{`COUNTER_CONTROL_RST}};
      pin_function_control <= {5{`PIN_FUNCTION_RST}};
      sync_group_control <= 5'h00;
      phase_count_enable <= 1'b0;
    end else if (init) begin
      counter_control <= {5{`COUNTER_CONTROL_RST}};
      pin_function_control <= {5{`PIN_FUNCTION_RST}};
      sync_group_control <= 5'h00;
      phase_count_enable <= 1'b0;
    end else if (wr_go & w_strb[0]) begin
      if (wr_hit_ch & wr_sub == `OFS_COUNTER_CONTROL)
        counter_control[sel_bit +: 8] <= {1'b0, w_data[6:0]};
      if (wr_hit_ch & wr_sub == `OFS_PIN_FUNCTION)
        pin_function_control[sel_bit +: 8] <=
          {1'b0, w_data[6:4], 1'b1, w_data[2:0]};
      if (wr_hit_gl & wr_sub == `OFS_SYNC_GROUP)
        sync_group_control <= w_data[4:0];
      if (wr_hit_gl & wr_sub == `OFS_PHASE_COUNT)
        phase_count_enable <= w_data[2];
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  wire [2:0] rd_slot = s_axi_araddr[7:5];
  wire [2:0] rd_sub = s_axi_araddr[4:2];
  wire [5:0] rd_b8 = {3'h0, rd_slot} << 3;
  wire [6:0] rd_b16 = {4'h0, rd_slot} << 4;
  wire [3:0] rd_b3 = {1'b0, rd_slot} + {rd_slot, 1'b0};
  reg [31:0] rd_mux;
  reg rd_ok;

  always @* begin
    rd_mux = 32'h00000000;
    rd_ok = 1'b1;
    if (rd_slot < `GLOBAL_SLOT) begin
      case (rd_sub)
        `OFS_COUNTER_CONTROL:
          rd_mux[6:0] = counter_control[rd_b8 +: 7];
        `OFS_PIN_FUNCTION: begin
          rd_mux[6:0] = pin_function_control[rd_b8 +: 7];
          rd_mux[`FIXED_ONE_BIT] = 1'b1;
        end
        `OFS_CHANNEL_COUNTER: rd_mux[15:0] = cnt_bus[rd_b16 +: 16];
        `OFS_GENERAL_REG_A: rd_mux[15:0] = gra_bus[rd_b16 +: 16];
        `OFS_GENERAL_REG_B: rd_mux[15:0] = grb_bus[rd_b16 +: 16];
        `OFS_STATUS_FLAGS: rd_mux[2:0] = flag_bus[rd_b3 +: 3];
        default: rd_ok = 1'b0;
      endcase
    end else if (rd_slot == `GLOBAL_SLOT) begin
      case (rd_sub)
        `OFS_SYNC_GROUP: rd_mux[4:0] = sync_group_control;
        `OFS_PHASE_COUNT: rd_mux[2] = phase_count_enable;
        default: rd_ok = 1'b0;
      endcase
    end else begin
      rd_ok = 1'b0;
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [sim/timer_unit_checker.sv]
// Purpose: Port-level assertions for the timer control block
// Assumes: One clock domain; rst is asynchronous and active high
// Notes: Bound into every timer_unit instance
`timescale 1ns/100ps
`default_nettype none
module timer_unit_checker (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  input wire standby,
  // Register bus
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  // Pins
  input wire [4:0] compare_capture_pin_a_out,
  input wire [4:0] compare_capture_pin_a_oe,
  input wire [4:0] compare_capture_pin_b_out,
  input wire [4:0] compare_capture_pin_b_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence ar_hs;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence w_hs;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_pf;
    ar_hs ##0 (s_axi_araddr[4:2] == 3'h1 && s_axi_araddr < 8'ha0);
  endsequence
  sequence rd_ctl;
    ar_hs ##0 (s_axi_araddr[4:3] == 2'h0 && s_axi_araddr < 8'ha0);
  endsequence
  chk_write_answer:
    assert property (w_hs |-> ##2 s_axi_bvalid)
    else $error("No write response after both handshakes");
  chk_read_answer:
    assert property (ar_hs |=> s_axi_rvalid)
    else $error("No read data after address handshake");
  chk_resp_single:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("Write response repeated");
  chk_aw_pulse:
    assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than one cycle");
  chk_fixed_one:
    assert property (rd_pf |=> s_axi_rvalid && s_axi_rdata[3])
    else $error("Pin function bit 3 read as 0");
  chk_bit7_quiet:
    assert property (rd_ctl |=> !s_axi_rdata[7])
    else $error("Control bit 7 read as 1");
  chk_reset_pins:
    assert property ($past(rst) |-> {compare_capture_pin_a_out,
      compare_capture_pin_a_oe, compare_capture_pin_b_out,
      compare_capture_pin_b_oe} == 20'h0)
    else $error("Pins not at 0 after reset");
  chk_standby_pins:
    assert property (standby [*2] |=> {compare_capture_pin_a_out,
      compare_capture_pin_a_oe, compare_capture_pin_b_out,
      compare_capture_pin_b_oe} == 20'h0)
    else $error("Pins not at 0 in standby");
  chk_oe_cause:
    assert property ($changed({compare_capture_pin_a_oe,
      compare_capture_pin_b_oe}) |-> s_axi_bvalid || $past(s_axi_bvalid)
      || $past(s_axi_bvalid, 2) || $past(standby) || $past(standby, 2))
    else $error("Pin enable changed without a write");
endmodule
bind timer_unit timer_unit_checker u_chk (
  .clk_sys, .rst, .standby, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .compare_capture_pin_a_out, .compare_capture_pin_a_oe,
  .compare_capture_pin_b_out, .compare_capture_pin_b_oe
);
`default_nettype wire

// [sim/timer_pins_model.sv]
// Purpose: Far side: external clock sources and capture inputs
// Assumes: Levels change right after clk_sys edges
// Notes: Inputs have no pull-ups, so every level is always driven
`timescale 1ns/100ps
`default_nettype none
module timer_pins_model (
  // Clock
  input wire logic clk_sys,
  // Levels toward the timer
  output logic [3:0] ext_clock_pin,
  output logic [4:0] cap_a,
  output logic [4:0] cap_b
);
  initial begin
    ext_clock_pin = 4'h0;
    cap_a = 5'h0;
    cap_b = 5'h0;
  end
  // Hold h cycles per level, longer than the synchroniser needs;
  // a larger h stands in for a slow source
  task automatic flip(input int w, input int i, input int n, input int h);
    repeat (n) begin
      repeat (h) @(posedge clk_sys);
      if (w == 0) begin
        ext_clock_pin[i] <= ~ext_clock_pin[i];
      end else begin
        cap_b[i] <= ~cap_b[i];
      end
    end
    repeat (8) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// [sim/timer_channel_clock_clear_io_control_tb_top.sv]
// Purpose: Self-checking bench for the timer control block
// Assumes: Bus answers within a few cycles; pins come from the model
// Notes: Prescaler timing is checked in windows to absorb bus latency
`timescale 1ns/100ps
`default_nettype none
module timer_channel_clock_clear_io_control_tb_top;
  logic clk_sys, rst, standby;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, p;
  logic [3:0] s_axi_wstrb, ext_clock_pin;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, lresp;
  logic [4:0] pa_in, pb_in, pa_out, pa_oe, pb_out, pb_oe;
  int fails = 0, checks = 0, cyc = 0, t0, c;
  int e1[4] = '{4, 3, 7, 7};
  int e2[4] = '{4, 4, 8, 8};
  timer_unit u_dut (
    .clk_sys, .rst, .standby, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_clock_pin,
    .compare_capture_pin_a_in(pa_in), .compare_capture_pin_a_out(pa_out),
    .compare_capture_pin_a_oe(pa_oe), .compare_capture_pin_b_in(pb_in),
    .compare_capture_pin_b_out(pb_out), .compare_capture_pin_b_oe(pb_oe)
  );
  timer_pins_model u_pins (
    .clk_sys, .ext_clock_pin, .cap_a(pa_in), .cap_b(pb_in)
  );
  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) cyc <= cyc + 1;
  function automatic logic [7:0] ad(input int ch, input int o);
    return 8'(ch * 32 + o);
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rng(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi) begin
      fails++;
      $display("[FAIL] %0t count %0d out of %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1 && n < 40);
    if (n >= 40) fails++;
    lresp = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1 && n < 40);
    if (n >= 40) fails++;
    d = s_axi_rdata;
  endtask
  task automatic stby;
    @(posedge clk_sys);
    standby <= 1'h1;
    repeat (2) @(posedge clk_sys);
    standby <= 1'h0;
  endtask
  // Cycles between two changes of a pin, after aligning on one change
  task automatic gap(input int ch, input int b, output logic [31:0] g);
    logic v;
    for (int k = 0; k < 2; k++) begin
      v = b ? pb_out[ch] : pa_out[ch];
      g = 0;
      do begin
        @(posedge clk_sys);
        g++;
      end while ((b ? pb_out[ch] : pa_out[ch]) === v && g < 200);
    end
  endtask
  task automatic test_done;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    test_done;
  end
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    rst = 1'h1;
    standby = 1'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_bready, s_axi_rready} = 2'h3;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    repeat (10) @(posedge clk_sys);
    rst <= 1'h0;
    for (c = 0; c < 5; c++) begin
      rd(ad(c, 0)); cmp(d, 32'h0);
      rd(ad(c, 4)); cmp(d, 32'h8);
    end
    wr(ad(0, 0), 32'hff);
    rd(ad(0, 0)); cmp(d, 32'h7f);
    wr(ad(0, 4), 32'hf7);
    rd(ad(0, 4)); cmp(d, 32'h7f);
    stby;
    rd(ad(0, 0)); cmp(d, 32'h0);
    rd(ad(0, 4)); cmp(d, 32'h8);
    wr(8'he0, 32'h0); cmp({30'h0, lresp}, 32'h2);
    for (c = 0; c < 4; c++) begin
      stby;
      wr(ad(0, 0), 32'(c));
      wr(ad(0, 4), 32'h0a);
      cmp({31'h0, pa_out[0]}, 32'h0);
      wr(ad(0, 8), 32'h0);
      t0 = cyc;
      wr(ad(0, 12), 32'h8);
      while (pa_out[0] !== 1'h1 && cyc - t0 < 200) @(posedge clk_sys);
      rng(cyc - t0, 7 << c, (9 << c) + 4);
    end
    for (c = 0; c < 4; c++) begin
      wr(ad(1, 0), 32'((c << 3) + 4 + c));
      wr(ad(1, 8), 32'h0);
      u_pins.flip(0, c, 7, 6 + c);
      rd(ad(1, 8)); cmp(d, 32'(e1[c]));
      u_pins.flip(0, c, 1, 6);
      rd(ad(1, 8)); cmp(d, 32'(e2[c]));
    end
    stby;
    wr(ad(0, 12), 32'h3);
    wr(ad(0, 16), 32'h5);
    wr(ad(0, 4), 32'h3b);
    for (c = 0; c < 2; c++) begin
      wr(ad(0, 0), 32'h20 << c);
      wr(ad(0, 8), 32'h0);
      gap(0, c, p); cmp(p, 32'(4 + 2 * c));
    end
    wr(ad(2, 12), 32'h3);
    wr(ad(2, 4), 32'h0b);
    wr(ad(2, 0), 32'h20);
    wr(ad(2, 8), 32'h0);
    repeat (20) @(posedge clk_sys);
    cmp({30'h0, pa_out[2], pa_oe[2]}, 32'h3);
    repeat (2) @(posedge clk_sys);
    cmp({31'h0, pa_out[2]}, 32'h1);
    wr(ad(0, 0), 32'h20);
    wr(ad(0, 8), 32'h0);
    wr(ad(1, 12), 32'h2);
    wr(ad(1, 4), 32'h0b);
    wr(ad(1, 0), 32'h60);
    wr(8'ha0, 32'h3);
    gap(1, 0, p); cmp(p, 32'h4);
    wr(8'ha4, 32'h4);
    wr(ad(2, 8), 32'h0);
    rd(ad(2, 8)); cmp(d, 32'h0);
    u_pins.flip(0, 0, 1, 6);
    rd(ad(2, 8)); cmp(d, 32'h1);
    for (c = 4; c < 8; c++) begin
      wr(ad(3, 4), 32'(8 + (c << 4)));
      wr(ad(3, 20), 32'h0);
      u_pins.flip(1, 3, 1, 6);
      rd(ad(3, 20)); cmp(d & 32'h2, c == 5 ? 32'h0 : 32'h2);
      wr(ad(3, 20), 32'h0);
      u_pins.flip(1, 3, 1, 7);
      rd(ad(3, 20)); cmp(d & 32'h2, c == 4 ? 32'h0 : 32'h2);
    end
    test_done;
  end
endmodule
`default_nettype wire
